// ### verilog/smps_seq.sv
// Protection, safe restart, burst and power-down sequencer with AXI4-Lite registers
// Function
// - Protect input below trip level latches off
// - Protect trip needs 2 to 3 ms low
// - Overtemperature stops switching, latches
// - On-time reaching 55 us ends, safe restart
// - Safe restart waits 800 ms idle
// - Restart: brown-in, sources up, soft-start, switch
// - Supply held at start-up after a safe restart or latch until output regulates; not after reset or supply reset
// - Latch keeps supply, never switches
// - Latch or restart enables supply discharge sink
// - Feedback below 0.5 V enters burst
// - Burst trims feedback source; normal ramps back
// - Burst frequency at most 800 Hz, 1250 us, except early start on load step
// - Pulse count tracks power, minimum three
// - Count changes only after half-pulse deviation
// - More than 40 pulses leaves burst
// - Feedback current over stop level ends burst window
// - Burst end pulls feedback low 12.5 us unless opto_lt87_in is high
// - Load step restarts burst early, adds pulses
// - Soft-start charged before every start
// - Power-down: feedback 0 V, burst, low source
// - Power-down blocks protect-input latch
// - Between thresholds, delay counts 1 ms ticks
module smps_seq #(
	parameter int ONMAX_CYC = smps_pkg::ONMAX_CYC,
	parameter int TICK_CYC = smps_pkg::TICK_CYC,
	parameter int RESTART_CYC = smps_pkg::RESTART_CYC,
	parameter int BURST_CYC = smps_pkg::BURST_CYC
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic prot_trip_in,
	input wire logic prot_pd_in,
	input wire logic otp_in,
	input wire logic mains_ok_in,
	input wire logic supply_reset_in,
	input wire logic prot_lvl_ok_in,
	input wire logic fb_lvl_ok_in,
	input wire logic ss_done_in,
	input wire logic out_reg_ok_in,
	input wire logic fb_low_in,
	input wire logic opto_lt80_in,
	input wire logic opto_lt87_in,
	input wire logic opto_gt100_in,
	input wire logic fb_stop_in,
	input wire logic pwm_on_in,
	output logic gate_out,
	output logic vcc_startup_out,
	output logic vcc_restart_out,
	output logic discharge_out,
	output logic prot_src_en_out,
	output logic prot_src_low_out,
	output logic fb_src_en_out,
	output logic fb_zero_out,
	output logic fb_pull_out,
	output logic fbv_up_out,
	output logic fbv_fast_out,
	output logic fbv_dn_out,
	output logic ss_charge_out,
	output logic burst_out,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam logic [12:0] ONMAX_LAST = 13'(ONMAX_CYC - 1);
	localparam logic [16:0] TICK_LAST = 17'(TICK_CYC - 1);
	localparam logic [26:0] RESTART_LAST = 27'(RESTART_CYC - 1);
	localparam logic [17:0] BURST_LAST = 18'(BURST_CYC - 1);
	localparam logic [11:0] GAP_LAST = 12'(smps_pkg::GAP_CYC - 1);
	localparam logic [10:0] PULL_LAST = 11'(smps_pkg::PULL_CYC - 1);

	typedef struct packed {
		smps_pkg::seq_e st;
		logic [1:0] filt;
		logic [16:0] tick;
		logic [12:0] oncnt;
		logic [26:0] rcnt;
		logic [17:0] bper;
		logic [11:0] gap;
		logic [10:0] pull;
		logic [5:0] np;
		logic [6:0] calc;
		logic [5:0] pcnt;
		logic burst;
		logic bon;
		logic [2:0] cause;
		logic gate;
		logic vstart;
		logic vrest;
		logic dis;
		logic psrc;
		logic plow;
		logic fsrc;
		logic fzero;
		logic fpull;
		logic vup;
		logic vfast;
		logic vdn;
		logic ss;
		logic run_en;
		logic aw_got;
		logic [3:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_s;

	state_s s_r;
	state_s s_nxt;
	logic rst_meta_r;
	logic rst_r;
	logic trip_s, pd_s, otp_s, mains_s, sup_rst_s, plvl_s, flvl_s, ssd_s;
	logic reg_s, fbl_s, lt80_s, lt87_s, gt100_s, stop_s;

	// ---------------------------------------------------------------
	// Reset release and input synchronisation
	// ---------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_meta_r <= 1'b0;
			rst_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_r <= rst_meta_r;
		end
	end

	sync2 #(.W(14)) u_sync (
		.clk_in(clk_in),
		.rstn_in(rst_r),
		.d_in({prot_trip_in, prot_pd_in, otp_in, mains_ok_in, supply_reset_in,
			prot_lvl_ok_in, fb_lvl_ok_in, ss_done_in, out_reg_ok_in, fb_low_in,
			opto_lt80_in, opto_lt87_in, opto_gt100_in, fb_stop_in}),
		.q_out({trip_s, pd_s, otp_s, mains_s, sup_rst_s, plvl_s, flvl_s, ssd_s,
			reg_s, fbl_s, lt80_s, lt87_s, gt100_s, stop_s})
	);

	// ---------------------------------------------------------------
	// Next-state logic
	// ---------------------------------------------------------------
	always_comb begin
		logic tick_p;
		logic pulse;
		logic gate_ok;
		logic aw_ok;
		logic ar_ok;
		tick_p = 1'b0;
		pulse = 1'b0;
		gate_ok = 1'b0;
		aw_ok = 1'b0;
		ar_ok = 1'b0;
		s_nxt = s_r;
		// Free-running 1 ms tick for the protect delay
		tick_p = (s_r.tick == TICK_LAST);
		s_nxt.tick = tick_p ? 17'h0 : s_r.tick + 17'h1;
		if (pd_s || !trip_s) begin
			s_nxt.filt = 2'h0;
		end else if (tick_p && s_r.filt != smps_pkg::FILT_TICKS) begin
			s_nxt.filt = s_r.filt + 2'h1;
		end
		s_nxt.oncnt = s_r.gate ? s_r.oncnt + 13'h1 : 13'h0;
		if (s_r.pull != 11'h0) begin
			s_nxt.pull = s_r.pull - 11'h1;
		end
		case (s_r.st)
		smps_pkg::ST_OFF: begin
			s_nxt.burst = 1'b0;
			s_nxt.bon = 1'b0;
			if (s_r.run_en && mains_s) begin
				s_nxt.st = smps_pkg::ST_SRC_UP;
			end
		end
		smps_pkg::ST_SRC_UP: begin
			if (plvl_s && flvl_s) begin
				s_nxt.st = smps_pkg::ST_SOFT;
			end
		end
		smps_pkg::ST_SOFT: begin
			if (ssd_s) begin
				s_nxt.st = smps_pkg::ST_RUN;
				s_nxt.np = smps_pkg::MIN_PULSES;
				s_nxt.calc = {smps_pkg::MIN_PULSES, 1'b0};
			end
		end
		smps_pkg::ST_RUN: begin
			if (reg_s) begin
				s_nxt.vstart = 1'b0;
			end
			if (!s_r.burst && (fbl_s || pd_s)) begin
				s_nxt.burst = 1'b1;
				s_nxt.bon = 1'b1;
				s_nxt.bper = 18'h0;
				s_nxt.pcnt = 6'h0;
				s_nxt.gap = 12'h0;
			end
			if (s_r.burst) begin
				if (s_r.bper != '1) begin
					s_nxt.bper = s_r.bper + 18'h1;
				end
				if (s_r.bon) begin
					pulse = pwm_on_in && !s_r.gate;
					s_nxt.gap = pulse ? 12'h0 : s_r.gap + 12'h1;
					if (pulse) begin
						s_nxt.pcnt = s_r.pcnt + 6'h1;
					end
					if (stop_s || s_r.gap == GAP_LAST || (!s_r.gate && s_r.pcnt >= s_r.np)) begin
						s_nxt.bon = 1'b0;
						s_nxt.pull = lt87_s ? 11'h0 : PULL_LAST;
						s_nxt.fpull = !lt87_s;
						if (s_r.pcnt > smps_pkg::MAX_PULSES && !pd_s) begin
							s_nxt.burst = 1'b0;
						end
					end
				end else if (s_r.pull == 11'h0 && (lt80_s || (s_r.bper >= BURST_LAST && (!fbl_s || pd_s)))) begin
					// early start on load step; late start lengthens period
					s_nxt.bon = 1'b1;
					s_nxt.bper = 18'h0;
					s_nxt.pcnt = 6'h0;
					s_nxt.gap = 12'h0;
					if (s_r.bper < BURST_LAST) begin
						s_nxt.calc = s_r.calc + 7'h1;
					end else if (s_r.bper > BURST_LAST) begin
						s_nxt.calc = s_r.calc - 7'h1;
					end
					if (s_nxt.calc >= {s_r.np, 1'b1} && s_r.np <= smps_pkg::MAX_PULSES) begin
						s_nxt.np = s_r.np + 6'h1;
						s_nxt.calc = {s_r.np + 6'h1, 1'b0};
					end else if (s_nxt.calc >= {s_r.np, 1'b1}) begin
						// Count stops one past the exit limit so it cannot wrap
						s_nxt.calc = {s_r.np, 1'b0};
					end else if (s_nxt.calc < {s_r.np, 1'b0} && s_r.np > smps_pkg::MIN_PULSES) begin
						s_nxt.np = s_r.np - 6'h1;
						s_nxt.calc = {s_r.np - 6'h1, 1'b0};
					end else if (s_nxt.calc < {s_r.np, 1'b0}) begin
						s_nxt.calc = {s_r.np, 1'b0};
					end
				end
			end
		end
		smps_pkg::ST_RESTART: begin
			s_nxt.rcnt = s_r.rcnt + 27'h1;
			if (s_r.rcnt == RESTART_LAST) begin
				s_nxt.st = smps_pkg::ST_OFF;
			end
		end
		smps_pkg::ST_LATCH: begin
			s_nxt.st = smps_pkg::ST_LATCH;
		end
		default: begin
			s_nxt.st = smps_pkg::ST_OFF;
		end
		endcase
		if (s_r.pull == 11'h0 || s_r.pull == 11'h1) begin
			s_nxt.fpull = s_nxt.pull != 11'h0;
		end
		// Protection entry, latch first
		if (s_r.st == smps_pkg::ST_RUN && s_r.gate && s_r.oncnt == ONMAX_LAST) begin
			s_nxt.st = smps_pkg::ST_RESTART;
			s_nxt.cause[2] = 1'b1;
		end
		if ((s_r.st == smps_pkg::ST_SOFT || s_r.st == smps_pkg::ST_RUN)
			&& s_r.filt == smps_pkg::FILT_TICKS && !pd_s) begin
			s_nxt.st = smps_pkg::ST_LATCH;
			s_nxt.cause[0] = 1'b1;
		end
		if (otp_s && s_r.st != smps_pkg::ST_LATCH) begin
			s_nxt.st = smps_pkg::ST_LATCH;
			s_nxt.cause[1] = 1'b1;
		end
		if (s_nxt.st == smps_pkg::ST_RESTART && s_r.st != smps_pkg::ST_RESTART) begin
			s_nxt.rcnt = 27'h0;
		end
		if (sup_rst_s) begin
			s_nxt.st = smps_pkg::ST_OFF;
			s_nxt.cause = 3'h0;
		end
		if (s_nxt.st == smps_pkg::ST_LATCH || s_nxt.st == smps_pkg::ST_RESTART) begin
			s_nxt.vstart = 1'b1;
		end else if (s_nxt.st == smps_pkg::ST_OFF && sup_rst_s) begin
			s_nxt.vstart = 1'b0;
		end
		// Pin drives
		gate_ok = s_nxt.st == smps_pkg::ST_RUN && (!s_nxt.burst || s_nxt.bon);
		s_nxt.gate = pwm_on_in && gate_ok && s_r.st == smps_pkg::ST_RUN
			&& !(s_r.gate && s_r.oncnt == ONMAX_LAST);
		s_nxt.dis = s_nxt.st == smps_pkg::ST_LATCH || s_nxt.st == smps_pkg::ST_RESTART;
		s_nxt.psrc = s_nxt.st == smps_pkg::ST_SRC_UP || s_nxt.st == smps_pkg::ST_SOFT
			|| s_nxt.st == smps_pkg::ST_RUN;
		s_nxt.fsrc = s_nxt.psrc;
		s_nxt.ss = s_nxt.st == smps_pkg::ST_SOFT;
		s_nxt.plow = pd_s;
		s_nxt.fzero = pd_s && s_nxt.psrc;
		s_nxt.vrest = pd_s && s_nxt.st == smps_pkg::ST_RUN;
		s_nxt.vfast = s_nxt.st == smps_pkg::ST_RUN && s_nxt.burst && !pd_s && lt80_s;
		s_nxt.vdn = s_nxt.st == smps_pkg::ST_RUN && s_nxt.burst && !pd_s && gt100_s;
		s_nxt.vup = s_nxt.st == smps_pkg::ST_RUN && !pd_s && !s_nxt.vdn && !s_nxt.vfast;
		// AXI4-Lite write side
		aw_ok = s_axi_awvalid && s_r.awready;
		if (aw_ok) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_r.wready) begin
			s_nxt.w_got = 1'b1;
			s_nxt.w_data = s_axi_wdata;
			s_nxt.w_strb = s_axi_wstrb;
		end
		if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = smps_pkg::RESP_SLVERR;
			if (s_r.aw_addr == smps_pkg::ADDR_CTRL) begin
				s_nxt.bresp = smps_pkg::RESP_OKAY;
				if (s_r.w_strb[0]) begin
					s_nxt.run_en = s_r.w_data[smps_pkg::CTRL_RUN_BIT];
				end
			end else if (s_r.aw_addr == smps_pkg::ADDR_STATUS) begin
				s_nxt.bresp = smps_pkg::RESP_OKAY;
			end
		end else if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
		s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;
		// AXI4-Lite read side
		ar_ok = s_axi_arvalid && s_r.arready;
		if (ar_ok) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = smps_pkg::RESP_OKAY;
			s_nxt.rdata = 32'h0;
			if (s_axi_araddr == smps_pkg::ADDR_CTRL) begin
				s_nxt.rdata[smps_pkg::CTRL_RUN_BIT] = s_r.run_en;
			end else if (s_axi_araddr == smps_pkg::ADDR_STATUS) begin
				s_nxt.rdata[15:0] = {s_r.np, s_r.cause, pd_s, s_r.bon, s_r.burst, 1'b0, s_r.st};
			end else begin
				s_nxt.rresp = smps_pkg::RESP_SLVERR;
			end
		end else if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		s_nxt.arready = !s_nxt.rvalid;
	end

	always_ff @(posedge clk_in or negedge rst_r) begin
		if (!rst_r) begin
			s_r <= '0;
			s_r.st <= smps_pkg::ST_OFF;
			s_r.np <= smps_pkg::MIN_PULSES;
			s_r.calc <= {smps_pkg::MIN_PULSES, 1'b0};
			s_r.run_en <= smps_pkg::CTRL_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign gate_out = s_r.gate;
	assign vcc_startup_out = s_r.vstart;
	assign vcc_restart_out = s_r.vrest;
	assign discharge_out = s_r.dis;
	assign prot_src_en_out = s_r.psrc;
	assign prot_src_low_out = s_r.plow;
	assign fb_src_en_out = s_r.fsrc;
	assign fb_zero_out = s_r.fzero;
	assign fb_pull_out = s_r.fpull;
	assign fbv_up_out = s_r.vup;
	assign fbv_fast_out = s_r.vfast;
	assign fbv_dn_out = s_r.vdn;
	assign ss_charge_out = s_r.ss;
	assign burst_out = s_r.burst;
	assign s_axi_awready = s_r.awready;
	assign s_axi_wready = s_r.wready;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_arready = s_r.arready;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rdata = s_r.rdata;
	assign s_axi_rresp = s_r.rresp;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	AST_OTP_LATCH: assert property (@(posedge clk_in) disable iff (!rst_r)
		otp_s && !sup_rst_s |=> s_r.st == smps_pkg::ST_LATCH && !s_r.gate)
		else $error("overtemperature did not latch");
	AST_ONTIME: assert property (@(posedge clk_in) disable iff (!rst_r)
		s_r.gate && s_r.oncnt == ONMAX_LAST |=> !s_r.gate)
		else $error("gate on-time exceeded limit");
	AST_LATCH_HOLD: assert property (@(posedge clk_in) disable iff (!rst_r)
		s_r.st == smps_pkg::ST_LATCH && !sup_rst_s |=> s_r.st == smps_pkg::ST_LATCH && !gate_out)
		else $error("latch released without supply reset");
	AST_DISCHARGE: assert property (@(posedge clk_in) disable iff (!rst_r)
		$rose(s_r.st == smps_pkg::ST_LATCH) |-> discharge_out && vcc_startup_out)
		else $error("discharge sink not enabled in latch");
	AST_PULL_SKIP: assert property (@(posedge clk_in) disable iff (!rst_r)
		$fell(s_r.bon) && s_r.burst && $past(lt87_s) |-> !fb_pull_out)
		else $error("feedback pull-down not skipped");
	AST_STOP_END: assert property (@(posedge clk_in) disable iff (!rst_r)
		s_r.st == smps_pkg::ST_RUN && s_r.burst && s_r.bon && stop_s |=> !s_r.bon)
		else $error("burst window not ended by stop level");
	AST_PD_BLOCK: assert property (@(posedge clk_in) disable iff (!rst_r)
		pd_s |=> s_r.filt == 2'h0)
		else $error("protect delay counted in power-down");
	AST_MIN_PULSES: assert property (@(posedge clk_in) disable iff (!rst_r)
		s_r.np >= smps_pkg::MIN_PULSES)
		else $error("burst pulse count below minimum");
	AST_SS_FIRST: assert property (@(posedge clk_in) disable iff (!rst_r)
		$rose(s_r.st == smps_pkg::ST_RUN) |-> $past(ss_charge_out))
		else $error("switching started without soft-start");
	AST_SUP_RST: assert property (@(posedge clk_in) disable iff (!rst_r)
		sup_rst_s |=> s_r.st == smps_pkg::ST_OFF ##1 !gate_out)
		else $error("supply reset did not clear sequencer");
endmodule : smps_seq

// ### shared/smps_pkg.sv
// Shared constants for the protection and burst sequencer
package smps_pkg;
	localparam int CLK_NS = 10;
	// ---------------------------------------------------------------
	// Times as specified
	// ---------------------------------------------------------------
	localparam int T_ONMAX_NS = 55000;
	localparam int T_TICK_NS = 1000000;
	localparam int T_RESTART_NS = 800000000;
	localparam int T_BURST_NS = 1250000;
	localparam int T_GAP_NS = 40000;
	localparam int T_PULL_NS = 12500;
	// ---------------------------------------------------------------
	// Derived cycle counts
	// ---------------------------------------------------------------
	localparam int ONMAX_CYC = T_ONMAX_NS / CLK_NS;
	localparam int TICK_CYC = T_TICK_NS / CLK_NS;
	localparam int RESTART_CYC = T_RESTART_NS / CLK_NS;
	localparam int BURST_CYC = T_BURST_NS / CLK_NS;
	localparam int GAP_CYC = T_GAP_NS / CLK_NS;
	localparam int PULL_CYC = T_PULL_NS / CLK_NS;
	localparam logic [1:0] FILT_TICKS = 2'h3;
	localparam logic [5:0] MIN_PULSES = 6'h03;
	localparam logic [5:0] MAX_PULSES = 6'h28;
	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam int CTRL_RUN_BIT = 0;
	localparam logic CTRL_RST = 1'b0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ---------------------------------------------------------------
	// Sequencer states
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_SRC_UP = 3'h1,
		ST_SOFT = 3'h2,
		ST_RUN = 3'h3,
		ST_RESTART = 3'h4,
		ST_LATCH = 3'h5
	} seq_e;
endpackage : smps_pkg

// ### verilog/sync2.sv
// Two-stage synchroniser for a group of asynchronous levels
module sync2 #(
	parameter int W = 1
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			meta_r <= '0;
			q_out <= '0;
		end else begin
			meta_r <= d_in;
			q_out <= meta_r;
		end
	end
endmodule : sync2

// ### verif/flyback_plant.sv
// Model of the power stage, feedback and protect network as seen through comparators
module flyback_plant #(
	parameter int DLY = 6
) (
	input wire logic clk_in,
	input wire logic prot_src_en_in,
	input wire logic fb_src_en_in,
	input wire logic ss_charge_in,
	input wire logic gate_in,
	output logic prot_lvl_ok_out,
	output logic fb_lvl_ok_out,
	output logic ss_done_out,
	output logic out_reg_ok_out
);
	timeunit 1ns;
	timeprecision 1ps;
	int pc = 0;
	int fc = 0;
	int sc = 0;
	int gc = 0;
	// ---------------------------------------------------------------
	// Pin levels build up only while their source is on
	// ---------------------------------------------------------------
	always @(posedge clk_in) begin
		pc <= prot_src_en_in ? pc + 1 : 0;
		fc <= fb_src_en_in ? fc + 1 : 0;
		sc <= ss_charge_in ? sc + 1 : 0;
		gc <= prot_src_en_in ? gc + int'(gate_in) : 0;
	end
	// Feedback settles slower than protect, so the sequencer must wait for both
	assign prot_lvl_ok_out = pc > DLY;
	assign fb_lvl_ok_out = fc > 3 * DLY;
	assign ss_done_out = sc > 2 * DLY;
	assign out_reg_ok_out = gc > 4 * DLY;
endmodule : flyback_plant

// ### verif/tb.sv
// Self-checking bench for the protection and burst sequencer
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int ON = 50;
	localparam int RS = 200;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic prot_trip_in = 1'b0, prot_pd_in = 1'b0, otp_in = 1'b0, mains_ok_in = 1'b0;
	logic supply_reset_in = 1'b0, fb_low_in = 1'b0, fb_stop_in = 1'b0, pwm_on_in = 1'b0;
	logic opto_lt80_in = 1'b0, opto_lt87_in = 1'b0, opto_gt100_in = 1'b0;
	logic prot_lvl_ok_in, fb_lvl_ok_in, ss_done_in, out_reg_ok_in;
	logic gate_out, vcc_startup_out, vcc_restart_out, discharge_out, prot_src_en_out;
	logic prot_src_low_out, fb_src_en_out, fb_zero_out, fb_pull_out, fbv_up_out;
	logic fbv_fast_out, fbv_dn_out, ss_charge_out, burst_out;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic pwm_auto = 1'b0, ss_seen = 1'b0, early = 1'b0, pull_seen = 1'b0;
	logic [4:0] pcnt = 5'h0;
	int on_run = 0, on_max = 0, failures = 0, n_tests = 0;
	typedef struct packed {
		logic wr;
		logic [3:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
		logic [1:0] resp;
	} row_s;
	row_s rows [0:8];

	always #5 clk_in = ~clk_in;

	smps_seq #(.ONMAX_CYC(ON), .TICK_CYC(20), .RESTART_CYC(RS), .BURST_CYC(300)) dut (.*);

	flyback_plant #(.DLY(6)) plant (.clk_in(clk_in), .prot_src_en_in(prot_src_en_out),
		.fb_src_en_in(fb_src_en_out), .ss_charge_in(ss_charge_out), .gate_in(gate_out),
		.prot_lvl_ok_out(prot_lvl_ok_in), .fb_lvl_ok_out(fb_lvl_ok_in),
		.ss_done_out(ss_done_in), .out_reg_ok_out(out_reg_ok_in));
	// ---------------------------------------------------------------
	// Gate requests and output monitors
	// ---------------------------------------------------------------
	always @(posedge clk_in) begin
		pcnt <= pcnt + 5'h1;
		if (pwm_auto) pwm_on_in <= (pcnt < 5'h0a);
		if (ss_charge_out) ss_seen <= 1'b1;
		if (gate_out && !ss_seen) early <= 1'b1;
		if (fb_pull_out) pull_seen <= 1'b1;
		on_run <= gate_out ? on_run + 1 : 0;
		if (on_run > on_max) on_max <= on_run;
	end
	// ---------------------------------------------------------------
	// Checking and bus tasks
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic chb(input string nm, input logic got, input logic exp);
		chk(nm, {31'h0, got}, {31'h0, exp});
	endtask : chb
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		@(posedge clk_in);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		fork
			begin
				do @(posedge clk_in); while (s_axi_awready !== 1'b1);
				s_axi_awvalid <= 1'b0;
			end
			begin
				do @(posedge clk_in); while (s_axi_wready !== 1'b1);
				s_axi_wvalid <= 1'b0;
			end
		join
		while (s_axi_bvalid !== 1'b1) @(posedge clk_in);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_in);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk_in); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk_in); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic st(output logic [31:0] d);
		logic [1:0] r;
		rd(smps_pkg::ADDR_STATUS, d, r);
	endtask : st
	task automatic waitst(input logic [2:0] s);
		logic [31:0] d;
		do st(d); while (d[2:0] !== s);
	endtask : waitst
	task automatic clear_supply;
		@(posedge clk_in);
		supply_reset_in <= 1'b1;
		repeat (10) @(posedge clk_in);
		supply_reset_in <= 1'b0;
	endtask : clear_supply
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_sim

	initial begin
		repeat (20000) @(posedge clk_in);
		failures++;
		end_sim();
	end

	initial begin
		logic [31:0] d;
		logic [1:0] r;
		rows[0] = '{1'b0, smps_pkg::ADDR_CTRL, 32'h0, 4'hf, smps_pkg::RESP_OKAY};
		rows[1] = '{1'b1, 4'h8, 32'h1, 4'hf, smps_pkg::RESP_SLVERR};
		rows[2] = '{1'b0, 4'h8, 32'h0, 4'hf, smps_pkg::RESP_SLVERR};
		rows[3] = '{1'b1, smps_pkg::ADDR_CTRL, 32'h1, 4'he, smps_pkg::RESP_OKAY};
		rows[4] = '{1'b0, smps_pkg::ADDR_CTRL, 32'h0, 4'hf, smps_pkg::RESP_OKAY};
		rows[5] = '{1'b1, smps_pkg::ADDR_STATUS, 32'hffff, 4'hf, smps_pkg::RESP_OKAY};
		rows[6] = '{1'b1, smps_pkg::ADDR_CTRL, 32'h1, 4'hf, smps_pkg::RESP_OKAY};
		rows[7] = '{1'b0, smps_pkg::ADDR_CTRL, 32'h1, 4'hf, smps_pkg::RESP_OKAY};
		rows[8] = '{1'b0, smps_pkg::ADDR_STATUS, 32'h0, 4'hf, smps_pkg::RESP_OKAY};
		repeat (11) @(posedge clk_in);
		chk("outs in reset", {18'h0, gate_out, discharge_out, ss_charge_out, burst_out,
			prot_src_en_out, fb_src_en_out, fb_pull_out, s_axi_awready, s_axi_bvalid,
			s_axi_arready, s_axi_rvalid, vcc_startup_out, vcc_restart_out, fb_zero_out}, 32'h0);
		@(posedge clk_in);
		rstn_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		// Register rows: writes check the response, reads check data and response
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				wr(rows[i].addr, rows[i].data, rows[i].strb, r);
			end else begin
				rd(rows[i].addr, d, r);
				chk("rdata", d & 32'h3ff, rows[i].data);
			end
			chk("resp", {30'h0, r}, {30'h0, rows[i].resp});
		end
		$display("test registers done");
		mains_ok_in <= 1'b1;
		waitst(3'h3);
		chb("prot src", prot_src_en_out, 1'b1);
		chb("fb src", fb_src_en_out, 1'b1);
		chb("fb up", fbv_up_out, 1'b1);
		chb("gate before ss", early, 1'b0);
		$display("test startup done");
		pwm_on_in <= 1'b1;
		waitst(3'h4);
		chk("on max", {31'h0, on_max inside {[ON - 2:ON]}}, 32'h1);
		chb("gate off", gate_out, 1'b0);
		chb("discharge", discharge_out, 1'b1);
		chb("vcc startup", vcc_startup_out, 1'b1);
		ss_seen = 1'b0;
		pwm_on_in <= 1'b0;
		repeat (RS * 3 / 4) @(posedge clk_in);
		st(d);
		chk("still waiting", {29'h0, d[2:0]}, 32'h4);
		pwm_auto <= 1'b1;
		waitst(3'h3);
		chb("gate before ss", early, 1'b0);
		$display("test ontime done");
		prot_trip_in <= 1'b1;
		repeat (30) @(posedge clk_in);
		st(d);
		chk("trip filtered", {29'h0, d[2:0]}, 32'h3);
		repeat (60) @(posedge clk_in);
		st(d);
		chk("trip latch", {29'h0, d[2:0]}, 32'h5);
		chb("trip cause", d[7], 1'b1);
		prot_trip_in <= 1'b0;
		repeat (30) @(posedge clk_in);
		chb("latch gate", gate_out, 1'b0);
		chb("latch vcc", vcc_startup_out, 1'b1);
		chb("latch discharge", discharge_out, 1'b1);
		st(d);
		chk("latch holds", {29'h0, d[2:0]}, 32'h5);
		clear_supply();
		st(d);
		chk("causes cleared", {29'h0, d[9:7]}, 32'h0);
		chb("not latched", d[2:0] == 3'h5, 1'b0);
		waitst(3'h3);
		$display("test protect done");
		otp_in <= 1'b1;
		repeat (10) @(posedge clk_in);
		st(d);
		chk("otp latch", {29'h0, d[2:0]}, 32'h5);
		chb("otp cause", d[8], 1'b1);
		otp_in <= 1'b0;
		clear_supply();
		waitst(3'h3);
		$display("test otp done");
		fb_low_in <= 1'b1;
		opto_gt100_in <= 1'b1;
		repeat (20) @(posedge clk_in);
		chb("burst", burst_out, 1'b1);
		chb("fb down", fbv_dn_out, 1'b1);
		opto_gt100_in <= 1'b0;
		opto_lt80_in <= 1'b1;
		opto_lt87_in <= 1'b1;
		repeat (10) @(posedge clk_in);
		chb("fb fast", fbv_fast_out, 1'b1);
		pull_seen = 1'b0;
		repeat (700) @(posedge clk_in);
		chb("pull skipped", pull_seen, 1'b0);
		st(d);
		chb("pulses added", d[15:10] > smps_pkg::MIN_PULSES, 1'b1);
		opto_lt80_in <= 1'b0;
		opto_lt87_in <= 1'b0;
		repeat (5) @(posedge clk_in);
		pull_seen = 1'b0;
		repeat (700) @(posedge clk_in);
		chb("pull", pull_seen, 1'b1);
		$display("test burst done");
		prot_pd_in <= 1'b1;
		prot_trip_in <= 1'b1;
		repeat (150) @(posedge clk_in);
		chb("fb zero", fb_zero_out, 1'b1);
		chb("src low", prot_src_low_out, 1'b1);
		chb("vcc restart", vcc_restart_out, 1'b1);
		chb("pd burst", burst_out, 1'b1);
		st(d);
		chb("pd no latch", d[2:0] == 3'h5, 1'b0);
		// Stop level ends every window at once, so no gate pulse lasts
		fb_stop_in <= 1'b1;
		opto_lt87_in <= 1'b1;
		repeat (5) @(posedge clk_in);
		on_max <= 0;
		repeat (1500) @(posedge clk_in);
		chb("stop cuts burst", on_max < 2, 1'b1);
		$display("test powerdown done");
		end_sim();
	end
endmodule : tb
